// ==== logic/sync_tx_regs.svh ====
// register offsets, field positions and reset values of the sync transmitter
`ifndef SYNC_TX_REGS_SVH
`define SYNC_TX_REGS_SVH
`define CTRL_OFFSET         12'h000
`define RATE_OFFSET         12'h004
`define DATA_OFFSET         12'h008
`define STATUS_OFFSET       12'h00C
`define MASK_OFFSET         12'h010
`define CTRL_SYNC_BIT       0
`define CTRL_PORT_ON_BIT    1
`define CTRL_MASTER_BIT     2
`define CTRL_SINGLE_RECEIVE_ON_BIT       3
`define CTRL_CONTINUOUS_RECEIVE_ON_BIT       4
`define CTRL_TX_ON_BIT      5
`define CTRL_NINTH_SEL_BIT  6
`define CTRL_NINTH_VAL_BIT  7
`define CTRL_IDLE_HIGH_BIT  8
`define CTRL_HIGH_RATE_BIT  9
`define CTRL_WIDE_DIV_BIT   10
`define CTRL_TX_IRQ_BIT     11
`define CTRL_PERIPH_IRQ_BIT 12
`define CTRL_GLOBAL_IRQ_BIT 13
`define CTRL_RESET          14'h0000
`define RATE_RESET          16'h0000
`define STAT_BUF_EMPTY_BIT  0
`define STAT_DONE_BIT       1
`define STAT_RESET          2'h0
`define MASK_RESET          2'h0
`endif

// ==== logic/sync_tx_pkg.sv ====
// types shared by the sync transmitter
package sync_tx_pkg;
    typedef enum logic [1:0] {
        st_idle,
        st_lead,
        st_trail
    } shift_state_t;
    typedef logic [8:0] char_t;
endpackage : sync_tx_pkg

// ==== logic/sync_serial_master_transmit.sv ====
// synchronous serial master transmitter with an apb register file
// Function
// - master mode needs clocked mode, port on and master clock source
// - both receive enables must be clear for transmission
// - characters are sent only while transmit on is set
// - ninth bit select gives nine data bits, else eight
// - interrupt needs transmit, peripheral group and global enables all set
// - writing the holding buffer starts transmission when fully configured
// - new character waits in holding buffer until shift register empties
// - one clock per bit; data changes on leading edge
// - idle high select sets clock rest level and data edge
// - no start or stop bits; clock and data drivers enabled
`timescale 1ns/10ps
`include "sync_tx_regs.svh"
module sync_serial_master_transmit (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // serial link
    output logic             clock_line_pin_o,
    output logic             clock_line_pin_oe_o,
    output logic             data_line_pin_o,
    output logic             data_line_pin_oe_o,
    // interrupt
    output logic             irq_o
);
    import sync_tx_pkg::*;

    logic [13:0]  ctrl;
    logic [15:0]  rate;
    logic [1:0]   status;
    logic [1:0]   mask;
    sync_tx_pkg::char_t hold_buf;
    logic         hold_full;
    sync_tx_pkg::char_t shift_reg;
    logic [3:0]   bits_left;
    shift_state_t state;
    logic [15:0]  div_cnt;
    logic         clk_level;
    logic         data_bit;

    // apb decode
    wire access   = psel_i & penable_i;
    wire wr       = access & pwrite_i;
    wire hit_ctrl = paddr_i == `CTRL_OFFSET;
    wire hit_rate = paddr_i == `RATE_OFFSET;
    wire hit_data = paddr_i == `DATA_OFFSET;
    wire hit_stat = paddr_i == `STATUS_OFFSET;
    wire hit_mask = paddr_i == `MASK_OFFSET;
    wire mapped   = hit_ctrl | hit_rate | hit_data | hit_stat | hit_mask;

    wire master_mode = ctrl[`CTRL_SYNC_BIT] & ctrl[`CTRL_PORT_ON_BIT]
                     & ctrl[`CTRL_MASTER_BIT];
    wire rx_off      = ~ctrl[`CTRL_SINGLE_RECEIVE_ON_BIT] & ~ctrl[`CTRL_CONTINUOUS_RECEIVE_ON_BIT];
    wire tx_mode     = master_mode & rx_off & ctrl[`CTRL_TX_ON_BIT];
    wire ninth_sel   = ctrl[`CTRL_NINTH_SEL_BIT];
    wire idle_high   = ctrl[`CTRL_IDLE_HIGH_BIT];

    // write into the holding buffer: refused while it is still full
    wire data_wr  = wr & hit_data & tx_mode & ~hold_full;
    // half a bit period per tick; the wide bit only picks full or low-byte divisor software sets, high-rate bit unused
    wire [15:0] half_div = ctrl[`CTRL_WIDE_DIV_BIT] ? rate : {8'h00, rate[7:0]};
    wire tick     = (div_cnt == 16'h0000);
    wire load     = (state == st_idle) & hold_full & tx_mode;
    wire last_bit = (bits_left == 4'h1);
    wire done_evt = tick & (state == st_trail) & last_bit;
    wire [3:0] char_len = ninth_sel ? 4'h9 : 4'h8;

    wire [1:0] events = {done_evt, load};
    wire [1:0] clr    = (wr & hit_stat) ? pwdata_i[1:0] : 2'h0;
    wire [1:0] next_status = events | (status & ~clr);
    wire irq_gate = ctrl[`CTRL_TX_IRQ_BIT] & ctrl[`CTRL_PERIPH_IRQ_BIT]
                  & ctrl[`CTRL_GLOBAL_IRQ_BIT];
    wire next_irq = irq_gate & |(next_status & mask);

    wire [31:0] rd_mux = hit_ctrl ? {18'h00000, ctrl} :
                         hit_rate ? {16'h0000, rate} :
                         hit_data ? {23'h000000, hold_buf} :
                         hit_stat ? {30'h00000000, status} :
                         hit_mask ? {30'h00000000, mask} : 32'h00000000;

    // register file
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl   <= `CTRL_RESET;
            rate   <= `RATE_RESET;
            mask   <= `MASK_RESET;
            status <= `STAT_RESET;
        end else begin
            if (wr & hit_ctrl) ctrl <= pwdata_i[13:0];
            if (wr & hit_rate) rate <= pwdata_i[15:0];
            if (wr & hit_mask) mask <= pwdata_i[1:0];
            status <= next_status;    // set wins over clear
        end
    end

    // apb answer: one access cycle, no wait states
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~mapped;
            prdata_o  <= rd_mux;
        end
    end

    // holding buffer; ninth bit taken from the control field at write time
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hold_buf  <= 9'h000;
            hold_full <= 1'b0;
        end else if (data_wr) begin
            hold_buf  <= {ctrl[`CTRL_NINTH_VAL_BIT], pwdata_i[7:0]};
            hold_full <= 1'b1;
        end else if (load) begin
            hold_full <= 1'b0;
        end
    end

    // half-bit divider, restarted at each load so the first edge is a full half period away
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) div_cnt <= 16'h0000;
        else if (load || tick) div_cnt <= half_div;
        else div_cnt <= div_cnt - 16'h0001;
    end

    // shifter: lead phase has data launched, trail phase ends the bit
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state     <= st_idle;
            shift_reg <= 9'h000;
            bits_left <= 4'h0;
            clk_level <= 1'b0;
            data_bit  <= 1'b0;
        end else begin
            unique case (state)
                st_idle: begin
                    clk_level <= 1'b0;
                    if (load) begin
                        // first bit placed with the leading edge
                        data_bit  <= hold_buf[0];
                        shift_reg <= {1'b0, hold_buf[8:1]};
                        bits_left <= char_len;
                        clk_level <= 1'b1;
                        state     <= st_lead;
                    end
                end
                st_lead: if (tick) begin
                    clk_level <= 1'b0;                                    // trailing edge
                    state     <= st_trail;
                end
                st_trail: if (tick) begin
                    if (last_bit) begin
                        // idle for one cycle; a waiting character loads on the next edge
                        state <= st_idle;
                    end else begin
                        data_bit  <= shift_reg[0];
                        shift_reg <= {1'b0, shift_reg[8:1]};
                        bits_left <= bits_left - 4'h1;
                        clk_level <= 1'b1;
                        state     <= st_lead;
                    end
                end
            endcase
        end
    end

    // pins: clock rest level follows polarity; no framing bits exist
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            clock_line_pin_o    <= 1'b0;
            clock_line_pin_oe_o <= 1'b0;
            data_line_pin_o     <= 1'b0;
            data_line_pin_oe_o  <= 1'b0;
            irq_o               <= 1'b0;
        end else begin
            clock_line_pin_o    <= clk_level ^ idle_high;
            clock_line_pin_oe_o <= tx_mode;
            data_line_pin_o     <= data_bit;
            data_line_pin_oe_o  <= tx_mode;
            irq_o               <= next_irq;
        end
    end
endmodule : sync_serial_master_transmit

// ==== test/sync_tx_properties.sv ====
// port-level assertions for the sync transmitter
`timescale 1ns/10ps
module sync_tx_properties (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        clock_line_pin_o,
    input wire logic        clock_line_pin_oe_o,
    input wire logic        data_line_pin_o,
    input wire logic        data_line_pin_oe_o,
    input wire logic        irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    AST_READY_FIRST: assert property (psel_i && penable_i && !$past(penable_i) |-> pready_o)
        else $error("no ready in first access cycle");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    AST_READY_IDLE: assert property (!psel_i |-> !pready_o)
        else $error("ready without select");
    AST_ERR_READ_ZERO: assert property (pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0)
        else $error("refused read not zero");
    AST_OE_PAIR: assert property (clock_line_pin_oe_o == data_line_pin_oe_o)
        else $error("drivers not enabled together");
    AST_DATA_ON_LEAD: assert property ($changed(data_line_pin_o) && $past(data_line_pin_oe_o)
        |-> $changed(clock_line_pin_o)) else $error("data moved off a clock edge");
    AST_HALF_BIT: assert property ($changed(clock_line_pin_o) && clock_line_pin_oe_o
        |=> $stable(clock_line_pin_o)[*3]) else $error("clock half period short");
    AST_RESET_QUIET: assert property ($fell(reset_i) |-> !pready_o && !irq_o && !clock_line_pin_oe_o)
        else $error("outputs active after reset");
    cover property ($rose(irq_o));
    cover property (pslverr_o);
    cover property ($changed(clock_line_pin_o) && clock_line_pin_oe_o);
endmodule : sync_tx_properties
bind sync_serial_master_transmit sync_tx_properties chk_u (.ref_clk_i, .reset_i, .psel_i,
    .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .clock_line_pin_o,
    .clock_line_pin_oe_o, .data_line_pin_o, .data_line_pin_oe_o, .irq_o);

// ==== test/sync_slave_model.sv ====
// behavioural sync slave taking master clock and data
`timescale 1ns/10ps
module sync_slave_model (
    input  wire logic        clk_line_i,
    input  wire logic        data_line_i,
    input  wire logic        idle_high_i,
    output logic      [17:0] shift_o,
    output int               count_o
);
    initial begin
        shift_o = 18'h00000;
        count_o = 0;
    end
    // trailing edge brings the line back to rest; data is settled there
    always @(clk_line_i) begin
        if (clk_line_i === idle_high_i) begin
            shift_o = {data_line_i, shift_o[17:1]};
            count_o = count_o + 1;
        end
    end
endmodule : sync_slave_model

// ==== test/sync_serial_master_transmit_bench.sv ====
// self-checking bench for the sync serial master transmitter
`timescale 1ns/10ps
`include "sync_tx_regs.svh"
module sync_serial_master_transmit_bench;
    logic        ref_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic        pready_o, pslverr_o, ck_o, ck_oe, dt_o, dt_oe, irq_o, err, idle_high = 0;
    logic [17:0] shift;
    int          count, fail_count = 0, n_checks = 0;
    // released clock pulled low, released data pulled high
    wire         ck_w = ck_oe ? ck_o : 1'b0;
    wire         dt_w = dt_oe ? dt_o : 1'b1;
    always #2.5 ref_clk_i = ~ref_clk_i;
    sync_serial_master_transmit dut_u (.ref_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .clock_line_pin_o(ck_o),
        .clock_line_pin_oe_o(ck_oe), .data_line_pin_o(dt_o), .data_line_pin_oe_o(dt_oe), .irq_o);
    sync_slave_model slave_u (.clk_line_i(ck_w), .data_line_i(dt_w), .idle_high_i(idle_high),
        .shift_o(shift), .count_o(count));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, wr, a, d};
        @(posedge ref_clk_i);
        penable_i <= 1;
        for (i = 0; i < 20 && pready_o !== 1'b1; i++) @(posedge ref_clk_i);
        {rd, err} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
        if (i == 20) begin check("apb ready", 0, 1); test_done; end
    endtask : apb
    task automatic wait_bits(input int n, input int c0);
        for (int i = 0; i < 2000 && count < c0 + n; i++) @(posedge ref_clk_i);
        repeat (20) @(posedge ref_clk_i);
        check("bit count", count, c0 + n);
        if (count != c0 + n) test_done;
    endtask : wait_bits
    task automatic t_regs;
        apb(0, `CTRL_OFFSET, 0); check("ctrl reset", rd, 0);
        apb(0, `RATE_OFFSET, 0); check("rate reset", rd, 0);
        apb(0, 12'hFFC, 0); check("unmapped err", err, 1);
        apb(1, `RATE_OFFSET, 32'h0103);
        apb(0, `RATE_OFFSET, 0); check("rate", rd, 32'h0103);
        $display("regs test done");
    endtask : t_regs
    task automatic t_frame(input logic [31:0] ctrl, input logic [7:0] ch, input int n);
        idle_high = ctrl[8];
        apb(1, `CTRL_OFFSET, ctrl);
        apb(1, `DATA_OFFSET, ch);
        wait_bits(n, count);
        check("char", shift >> (18 - n), (n == 9) ? {ctrl[7], ch} : ch);
        check("clock rest", ck_o, ctrl[8]);
        check("drivers on", {ck_oe, dt_oe}, 2'b11);
        $display("frame test done");
    endtask : t_frame
    task automatic t_back2back;
        int c0 = count;
        apb(1, `DATA_OFFSET, 8'h5A);
        apb(1, `DATA_OFFSET, 8'hC3);
        wait_bits(16, c0);
        check("two chars", shift[17:2], 16'hC35A);
        $display("back to back test done");
    endtask : t_back2back
    task automatic t_modes;
        logic [31:0] bad[6] = '{32'h26, 32'h25, 32'h23, 32'h2F, 32'h37, 32'h07};
        int c0 = count;
        foreach (bad[k]) begin
            apb(1, `CTRL_OFFSET, bad[k]);
            apb(1, `DATA_OFFSET, 8'h81);
            repeat (40) @(posedge ref_clk_i);
            check("drivers off", {ck_oe, dt_oe}, 0);
            check("no bits", count, c0);
        end
        $display("modes test done");
    endtask : t_modes
    task automatic t_irq;
        apb(1, `MASK_OFFSET, 1);
        t_frame(32'h3827, 8'h11, 8);
        check("irq on", irq_o, 1);
        apb(0, `STATUS_OFFSET, 0); check("status", rd, 3);
        apb(1, `CTRL_OFFSET, 32'h1827);
        repeat (2) @(posedge ref_clk_i);
        check("irq global off", irq_o, 0);
        apb(1, `CTRL_OFFSET, 32'h3827);
        apb(1, `STATUS_OFFSET, 3);
        repeat (2) @(posedge ref_clk_i);
        check("irq cleared", irq_o, 0);
        $display("irq test done");
    endtask : t_irq
    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_i <= 0;
        t_regs;
        t_frame(32'h27, 8'hA6, 8);
        t_frame(32'h1E7, 8'h3C, 9);
        t_modes;
        t_frame(32'h27, 8'h0F, 8);
        t_back2back;
        t_irq;
        test_done;
    end
endmodule : sync_serial_master_transmit_bench
